// [verilog/rfs_params.svh]
// How it works
// RQ1: Reset comes from power-on, watchdog time-out, stop-mode recovery or the reset pin.
// RQ2: Power-on and watchdog resets pull the reset pin low for the whole timer interval.
// RQ3: Outside drivers of the reset line are open-drain only; the pull-up gives high.
// RQ4: After the power-on timer expires the pin is released and only sampled.
// RQ5: Reset pin lows shorter than four clock periods are filtered out, no reset.
// RQ6: On the fifth clock after a valid low, internal reset is latched active.
// RQ7: Internal reset holds at least 18 clocks, longer while the pin stays low.
// RQ8: During reset the data strobe stays low and the address strobe toggles.
// RQ9: Fetch starts at the reset vector five to ten clocks after pin release.
// RQ10: The power-on reset output lasts 5 ms, timed by the power-on timer.
// RQ11: Stop-mode recovery keeps watchdog, stop, port two and port three mode registers.
// RQ12: Stop-mode recovery runs the power-on timer only when stop mode bit 5 is zero.
// RQ13: The reset pin passes a two-stage synchroniser before the filter counts it.
`ifndef RFS_PARAMS_SVH
`define RFS_PARAMS_SVH

`define RFS_CLK_MHZ           250
`define RFS_POR_TIME_US       5000
`define RFS_POR_CYC           (`RFS_POR_TIME_US * `RFS_CLK_MHZ)
`define RFS_FILT_CLKS         4
`define RFS_MIN_HOLD_CLKS     18
`define RFS_EXIT_CLKS         5
`define RFS_RESET_VECTOR      16'h000c
`define RFS_SMR_POR_BYPASS    5

`endif

// [verilog/rfs_pkg.sv]
package rfs_pkg;

    typedef enum logic [2:0] {
        RFS_ST_RUN  = 3'b001,
        RFS_ST_HOLD = 3'b010,
        RFS_ST_EXIT = 3'b100
    } rfs_state_t;

    typedef struct packed {
        logic data_strobe_n;
        logic address_strobe_n;
    } rfs_strobe_t;

    typedef struct packed {
        logic out;
        logic oe_b;
    } rfs_pin_t;

    typedef struct packed {
        logic power_on;
        logic watchdog;
        logic stop_recovery;
        logic external;
    } rfs_cause_t;

endpackage

// [verilog/rfs_por_timer.sv]
`timescale 1ns/100ps
`default_nettype none
module rfs_por_timer #(
    parameter int unsigned CYC = 1250000
) (
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic start,
    output logic      busy
);
    localparam int unsigned W = $clog2(CYC + 1);

    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;

    // A new start while running restarts the full interval
    always_comb begin
        nxt_cnt = cnt_ff;
        if (start) begin
            nxt_cnt = W'(CYC);
        end else if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - W'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign busy = (cnt_ff != '0);

    a_timer_start_busy: assert property (@(posedge ref_clk) disable iff (!rst_b)
        start |=> busy ##0 (cnt_ff == W'(CYC))) // RQ10
        else $error("power-on timer did not load on start");

    a_timer_counts_down: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (busy && !start) |=> (cnt_ff == $past(cnt_ff) - W'(1))) // RQ10
        else $error("power-on timer did not count down");

endmodule // rfs_por_timer
`default_nettype wire

// [verilog/rfs_reset_sequencer.sv]
`timescale 1ns/100ps
`default_nettype none
`include "rfs_params.svh"
module rfs_reset_sequencer #(
    parameter int unsigned POR_CYC       = `RFS_POR_CYC,
    parameter int unsigned FILT_CLKS     = `RFS_FILT_CLKS,
    parameter int unsigned MIN_HOLD_CLKS = `RFS_MIN_HOLD_CLKS,
    parameter int unsigned EXIT_CLKS     = `RFS_EXIT_CLKS
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    input  wire logic              wdt_timeout,
    input  wire logic              stop_recovery,
    input  wire logic [7:0]        stop_mode_reg,
    input  wire logic              reset_pin_in,
    output rfs_pkg::rfs_pin_t      reset_pin,
    output logic                   internal_rst,
    output rfs_pkg::rfs_strobe_t   strobes,
    output logic                   fetch_start,
    output logic [15:0]            fetch_addr,
    output logic                   mode_regs_keep,
    output rfs_pkg::rfs_cause_t    cause
);
    // Reset pin synchroniser
    logic pin_s1_ff;
    logic pin_s2_ff;
    logic pin_low;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_ff <= 1'b1;
            pin_s2_ff <= 1'b1;
        end else begin
            pin_s1_ff <= reset_pin_in;  // RQ13
            pin_s2_ff <= pin_s1_ff;     // RQ13
        end
    end

    assign pin_low = !pin_s2_ff;

    // Power-on event: one pulse on the first edge after reset release
    logic por_pend_ff;
    logic por_start;
    logic smr_start;
    logic smr_timer;
    logic timer_start;
    logic timer_busy;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            por_pend_ff <= 1'b1;
        end else begin
            por_pend_ff <= 1'b0;
        end
    end

    assign por_start   = por_pend_ff;
    assign smr_start   = stop_recovery;
    assign smr_timer   = stop_recovery && !stop_mode_reg[`RFS_SMR_POR_BYPASS];   // RQ12
    assign timer_start = por_start || wdt_timeout || smr_timer;                  // RQ10

    rfs_por_timer #(
        .CYC (POR_CYC)
    ) u_por_timer (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .start   (timer_start),
        .busy    (timer_busy)
    );

    // Sequencer state
    localparam int unsigned LW = $clog2(FILT_CLKS + 1);
    localparam int unsigned HW = $clog2(MIN_HOLD_CLKS + 1);
    localparam int unsigned EW = $clog2(EXIT_CLKS + 1);

    rfs_pkg::rfs_state_t   state_ff;
    rfs_pkg::rfs_state_t   nxt_state;
    logic [LW-1:0]         low_cnt_ff;
    logic [LW-1:0]         nxt_low_cnt;
    logic [HW-1:0]         hold_cnt_ff;
    logic [HW-1:0]         nxt_hold_cnt;
    logic [EW-1:0]         exit_cnt_ff;
    logic [EW-1:0]         nxt_exit_cnt;
    logic                  drive_ff;
    logic                  nxt_drive;
    logic                  keep_ff;
    logic                  nxt_keep;
    logic                  fetch_ff;
    logic                  nxt_fetch;
    rfs_pkg::rfs_strobe_t  strobe_ff;
    rfs_pkg::rfs_strobe_t  nxt_strobe;
    rfs_pkg::rfs_cause_t   cause_ff;
    rfs_pkg::rfs_cause_t   nxt_cause;
    logic                  ext_detect;
    logic                  any_start;
    logic                  hold_done;

    // Fifth consecutive low sample: four full periods low have passed
    assign ext_detect = pin_low && (low_cnt_ff == LW'(FILT_CLKS));        // RQ5 RQ6
    assign any_start  = por_start || wdt_timeout || smr_start;            // RQ1
    assign hold_done  = (hold_cnt_ff >= HW'(MIN_HOLD_CLKS)) && !pin_low
                        && !timer_busy;                                   // RQ7

    always_comb begin
        nxt_state    = state_ff;
        nxt_hold_cnt = hold_cnt_ff;
        nxt_exit_cnt = exit_cnt_ff;
        nxt_fetch    = 1'b0;
        nxt_keep     = keep_ff;
        nxt_cause    = cause_ff;
        nxt_low_cnt  = '0;
        if (pin_low && low_cnt_ff != LW'(FILT_CLKS)) begin
            nxt_low_cnt = low_cnt_ff + LW'(1);
        end else if (pin_low) begin
            nxt_low_cnt = low_cnt_ff;
        end
        if (any_start || (ext_detect && state_ff != rfs_pkg::RFS_ST_HOLD)) begin
            // Any start source, or a filtered pin low outside the hold state, restarts the minimum hold
            nxt_state    = rfs_pkg::RFS_ST_HOLD;                          // RQ1 RQ6
            nxt_hold_cnt = '0;
            nxt_cause    = '{power_on: por_start, watchdog: wdt_timeout,
                             stop_recovery: smr_start, external: ext_detect};
            // Mode registers survive only a pure stop-mode recovery
            nxt_keep     = smr_start && !por_start && !wdt_timeout && !ext_detect; // RQ11
        end else begin
            case (state_ff)
                rfs_pkg::RFS_ST_RUN: begin
                    nxt_keep = 1'b0;
                end
                rfs_pkg::RFS_ST_HOLD: begin
                    if (hold_cnt_ff != HW'(MIN_HOLD_CLKS)) begin
                        nxt_hold_cnt = hold_cnt_ff + HW'(1);              // RQ7
                    end
                    if (hold_done) begin
                        nxt_state    = rfs_pkg::RFS_ST_EXIT;
                        nxt_exit_cnt = '0;
                    end
                end
                rfs_pkg::RFS_ST_EXIT: begin
                    if (pin_low) begin
                        nxt_state    = rfs_pkg::RFS_ST_HOLD;
                        nxt_hold_cnt = '0;
                    end else if (exit_cnt_ff == EW'(EXIT_CLKS - 1)) begin
                        nxt_state = rfs_pkg::RFS_ST_RUN;
                        nxt_fetch = 1'b1;                                 // RQ9
                    end else begin
                        nxt_exit_cnt = exit_cnt_ff + EW'(1);
                    end
                end
                default: begin
                    nxt_state = rfs_pkg::RFS_ST_HOLD;
                end
            endcase
        end
        // Pin is pulled low only for power-on and watchdog causes
        if (por_start || wdt_timeout) begin
            nxt_drive = 1'b1;                                             // RQ2
        end else if (!timer_busy) begin
            nxt_drive = 1'b0;                                             // RQ4
        end else begin
            nxt_drive = drive_ff;
        end
        // One toggle per clock is the fastest this clock allows
        if (nxt_state == rfs_pkg::RFS_ST_HOLD) begin
            nxt_strobe.data_strobe_n    = 1'b0;                           // RQ8
            nxt_strobe.address_strobe_n = !strobe_ff.address_strobe_n;    // RQ8
        end else begin
            nxt_strobe.data_strobe_n    = 1'b1;
            nxt_strobe.address_strobe_n = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff    <= rfs_pkg::RFS_ST_HOLD;
            low_cnt_ff  <= '0;
            hold_cnt_ff <= '0;
            exit_cnt_ff <= '0;
            drive_ff    <= 1'b1;
            keep_ff     <= 1'b0;
            fetch_ff    <= 1'b0;
            strobe_ff   <= 2'b01;
            cause_ff    <= 4'h8;
        end else begin
            state_ff    <= nxt_state;
            low_cnt_ff  <= nxt_low_cnt;
            hold_cnt_ff <= nxt_hold_cnt;
            exit_cnt_ff <= nxt_exit_cnt;
            drive_ff    <= nxt_drive;
            keep_ff     <= nxt_keep;
            fetch_ff    <= nxt_fetch;
            strobe_ff   <= nxt_strobe;
            cause_ff    <= nxt_cause;
        end
    end

    // Open-drain: the high level comes from the pull-up only
    assign reset_pin      = '{out: 1'b0, oe_b: !drive_ff};                // RQ3
    assign internal_rst   = (state_ff == rfs_pkg::RFS_ST_HOLD);
    assign strobes        = strobe_ff;
    assign fetch_start    = fetch_ff;
    assign fetch_addr     = `RFS_RESET_VECTOR;
    assign mode_regs_keep = keep_ff;
    assign cause          = cause_ff;

    a_source_enters_reset: assert property (@(posedge ref_clk) disable iff (!rst_b)
        any_start |=> internal_rst) // RQ1
        else $error("reset source did not assert internal reset");

    a_pin_driven_low: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wdt_timeout |=> (!reset_pin.oe_b && timer_busy)) // RQ2
        else $error("watchdog reset did not drive the pin");

    a_pin_released: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (!timer_busy && !por_start && !wdt_timeout) |=> reset_pin.oe_b) // RQ4
        else $error("pin still driven after timer expiry");

    a_short_low_ignored: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (state_ff == rfs_pkg::RFS_ST_RUN && !any_start && !ext_detect)
        |=> !internal_rst) // RQ5
        else $error("reset taken without a valid filtered low");

    a_filter_latches: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (state_ff == rfs_pkg::RFS_ST_RUN && pin_low
         && low_cnt_ff == LW'(FILT_CLKS)) |=> internal_rst) // RQ6
        else $error("valid external low not latched");

    a_hold_minimum: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (internal_rst && hold_cnt_ff < HW'(MIN_HOLD_CLKS)) |=> internal_rst) // RQ7
        else $error("internal reset shorter than minimum");

    a_hold_while_low: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (internal_rst && pin_low) |=> internal_rst) // RQ7
        else $error("internal reset ended while pin low");

    // The first edge after release still sees reset values on both sides of $past
    a_strobes_in_reset: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ8
        (internal_rst && $past(internal_rst) && $past(rst_b)) |->
        (!strobes.data_strobe_n
         && strobes.address_strobe_n != $past(strobes.address_strobe_n)))
        else $error("strobes wrong during reset");

    // A new cause or a low pin during the exit count legally restarts the hold
    a_fetch_window: assert property (@(posedge ref_clk) disable iff (!rst_b) // RQ9
        ((internal_rst && hold_done && !any_start) ##1 (!any_start && !pin_low)[*5])
        |=> (fetch_start && fetch_addr == `RFS_RESET_VECTOR))
        else $error("fetch not started in window after release");

    a_smr_bypass: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (stop_recovery && stop_mode_reg[`RFS_SMR_POR_BYPASS] && !timer_busy
         && !por_start && !wdt_timeout) |=> !timer_busy) // RQ12
        else $error("timer ran despite bypass bit");

    a_smr_keeps_modes: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (stop_recovery && !por_start && !wdt_timeout && !ext_detect)
        |=> (mode_regs_keep && cause.stop_recovery)) // RQ11
        else $error("mode registers not kept on stop recovery");

endmodule // rfs_reset_sequencer
`default_nettype wire

// [testbench/rfs_ext_src.sv]
`timescale 1ns/100ps
`default_nettype none
// Outside reset source on the shared pad: it may only pull low, never drive high
module rfs_ext_src (
    input  wire logic             pull_low,
    input  wire rfs_pkg::rfs_pin_t dev_pin,
    output logic                  pad
);
    logic dev_low;

    assign dev_low = (dev_pin.oe_b === 1'b0) && (dev_pin.out === 1'b0);
    // Released by both parties the pad sits at the pull-up level
    assign pad = (pull_low || dev_low) ? 1'b0 : 1'b1;
endmodule // rfs_ext_src
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("unexpected %s: expected %h, seen %h", nm, exp, got); end end
module testbench;
    logic                 ref_clk;
    logic                 rst_b;
    logic                 wdt_timeout;
    logic                 stop_recovery;
    logic [7:0]           stop_mode_reg;
    logic                 ext_low;
    logic                 pad;
    rfs_pkg::rfs_pin_t    reset_pin;
    logic                 internal_rst;
    rfs_pkg::rfs_strobe_t strobes;
    logic                 fetch_start;
    logic [15:0]          fetch_addr;
    logic                 mode_regs_keep;
    rfs_pkg::rfs_cause_t  cause;
    int                   n_mismatch;
    int                   checked;

    // Short power-on interval keeps the run brief
    rfs_reset_sequencer #(.POR_CYC(50)) DUT (
        .ref_clk(ref_clk), .rst_b(rst_b), .wdt_timeout(wdt_timeout),
        .stop_recovery(stop_recovery), .stop_mode_reg(stop_mode_reg),
        .reset_pin_in(pad), .reset_pin(reset_pin), .internal_rst(internal_rst),
        .strobes(strobes), .fetch_start(fetch_start), .fetch_addr(fetch_addr),
        .mode_regs_keep(mode_regs_keep), .cause(cause));

    rfs_ext_src ext (.pull_low(ext_low), .dev_pin(reset_pin), .pad(pad));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic wait_fetch(input int lim, output int n);
        n = 0;
        while (fetch_start !== 1'b1 && n < lim) begin
            @(negedge ref_clk);
            n++;
        end
        `CHK("fetch_start", 1'b1, fetch_start)
        `CHK("fetch_addr", 16'h000c, fetch_addr)
    endtask

    task automatic pulse(input logic wdt);
        if (wdt) wdt_timeout = 1'b1;
        else stop_recovery = 1'b1;
        @(negedge ref_clk);
        wdt_timeout = 1'b0;
        stop_recovery = 1'b0;
    endtask

    task automatic t_power_on();
        int n;
        repeat (10) @(negedge ref_clk);
        `CHK("oe_b por", 1'b0, reset_pin.oe_b)
        `CHK("cause por", 4'h8, cause)
        wait_fetch(200, n);
        `CHK("por length", 1'b1, n >= 40)
        @(negedge ref_clk);
        `CHK("oe_b released", 1'b1, reset_pin.oe_b)
    endtask

    task automatic t_short_pulse();
        ext_low = 1'b1;
        repeat (4) @(negedge ref_clk);
        ext_low = 1'b0;
        repeat (12) @(negedge ref_clk);
        `CHK("rst short", 1'b0, internal_rst)
    endtask

    task automatic t_ext_long();
        int n;
        logic a;
        ext_low = 1'b1;
        repeat (5) @(negedge ref_clk);
        `CHK("rst early", 1'b0, internal_rst)
        repeat (4) @(negedge ref_clk);
        `CHK("rst latched", 1'b1, internal_rst)
        `CHK("ds low", 1'b0, strobes.data_strobe_n)
        `CHK("oe_b ext", 1'b1, reset_pin.oe_b)
        a = strobes.address_strobe_n;
        @(negedge ref_clk);
        `CHK("as toggle", ~a, strobes.address_strobe_n)
        repeat (30) @(negedge ref_clk);
        `CHK("rst long", 1'b1, internal_rst)
        `CHK("cause ext", 4'h1, cause)
        ext_low = 1'b0;
        wait_fetch(20, n);
        `CHK("exit delay", 1'b1, n >= 5 && n <= 10)
        `CHK("keep ext", 1'b0, mode_regs_keep)
        repeat (2) @(negedge ref_clk);
        `CHK("rst done", 1'b0, internal_rst)
        `CHK("strobes idle", 2'b11, strobes)
    endtask

    task automatic t_min_hold();
        int n;
        int cnt;
        ext_low = 1'b1;
        repeat (6) @(negedge ref_clk);
        ext_low = 1'b0;
        cnt = 0;
        n = 0;
        while (internal_rst !== 1'b1 && n < 12) begin
            @(negedge ref_clk);
            n++;
        end
        while (internal_rst === 1'b1 && cnt < 60) begin
            @(negedge ref_clk);
            cnt++;
        end
        `CHK("hold count", 1'b1, cnt >= 18)
        wait_fetch(20, n);
        repeat (2) @(negedge ref_clk);
    endtask

    task automatic t_watchdog();
        int n;
        pulse(1'b1);
        `CHK("rst wdt", 1'b1, internal_rst)
        `CHK("oe_b wdt", 1'b0, reset_pin.oe_b)
        `CHK("pad wdt", 1'b0, pad)
        `CHK("cause wdt", 4'h4, cause)
        repeat (40) @(negedge ref_clk);
        `CHK("oe_b wdt hold", 1'b0, reset_pin.oe_b)
        wait_fetch(100, n);
        `CHK("oe_b wdt end", 1'b1, reset_pin.oe_b)
        repeat (3) @(negedge ref_clk);
    endtask

    task automatic t_stop(input logic bypass);
        int n;
        stop_mode_reg = bypass ? 8'h20 : 8'h00;
        pulse(1'b0);
        `CHK("rst stop", 1'b1, internal_rst)
        `CHK("cause stop", 4'h2, cause)
        `CHK("oe_b stop", 1'b1, reset_pin.oe_b)
        wait_fetch(100, n);
        `CHK("stop timer", ~bypass, n >= 40)
        `CHK("keep stop", 1'b1, mode_regs_keep)
        repeat (3) @(negedge ref_clk);
    endtask

    task automatic print_verdict();
        if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #20000;
        n_mismatch++;
        print_verdict();
    end

    initial begin
        n_mismatch = 0;
        checked = 0;
        rst_b = 1'b0;
        wdt_timeout = 1'b0;
        stop_recovery = 1'b0;
        stop_mode_reg = 8'h00;
        ext_low = 1'b0;
        repeat (5) @(negedge ref_clk);
        rst_b = 1'b1;
        t_power_on();
        t_short_pulse();
        t_ext_long();
        t_min_hold();
        t_watchdog();
        t_stop(1'b1);
        t_stop(1'b0);
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
